// ==== include/psc_pkg.sv ====
// Shared constants and types for the per-second performance counters
package psc_pkg;
    // Clock rate and length of one classified second
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned SECOND_MS     = 1000;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * SECOND_MS;

    // Length of the run that opens or closes unavailable time, in seconds
    localparam int unsigned WIN_SECONDS   = 10;

    // Inverse of the severe error ratio (one error in this many bits)
    localparam int unsigned SES_RATIO_INV = 1000;

    // Widths
    localparam int unsigned CNT_W         = 32;
    localparam int unsigned IN_W          = 16;
    localparam int unsigned ERR_AW        = 32;
    localparam int unsigned BIT_AW        = 48;
    localparam int unsigned PROD_W        = BIT_AW + 1;
    localparam int unsigned RUN_W         = 4;
    localparam int unsigned FLAG_N        = 6;

    // Derived run limits
    localparam logic [RUN_W-1:0] RUN_LAST  = RUN_W'(WIN_SECONDS - 1);
    localparam logic [CNT_W-1:0] WIN_CNT   = CNT_W'(WIN_SECONDS);
    localparam logic [CNT_W-1:0] LEAVE_SUB = CNT_W'(WIN_SECONDS - 1);

    // Reset values
    localparam logic [CNT_W-1:0] CNT_RST   = 32'h0;
    localparam logic [RUN_W-1:0] RUN_RST   = 4'h0;

    typedef logic [CNT_W-1:0] psc_cnt_t;

    // Per-cycle indications from the receive path
    typedef struct packed {
        logic [IN_W-1:0] pat_err_cnt;
        logic [IN_W-1:0] pat_bit_cnt;
        logic            lof;
        logic            los;
        logic            link_up;
        logic            remote_fault;
        logic            errored_frame;
    } psc_rx_ind_t;

    // Result counters, all in seconds
    typedef struct packed {
        psc_cnt_t total_time;
        psc_cnt_t unavailable_time;
        psc_cnt_t available_time;
        psc_cnt_t errored_seconds;
        psc_cnt_t severe_errored_seconds;
        psc_cnt_t alarm_second_count;
        psc_cnt_t error_free_second_count;
    } psc_counts_t;

    // Availability tracking
    typedef enum logic [1:0] {
        PSC_AVAIL = 2'b00,
        PSC_ENTER = 2'b01,
        PSC_UNAV  = 2'b10,
        PSC_LEAVE = 2'b11
    } psc_state_t;
endpackage

// ==== hw/psc_sec_latch.sv ====
// Saturating per-second accumulator, a sticky OR when one bit wide
`timescale 1ns/1ps
module psc_sec_latch #(
    parameter int unsigned IN_W  = 16,
    parameter int unsigned ACC_W = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             clr_i,
    input  wire logic [IN_W-1:0]  in_i,
    output logic      [ACC_W-1:0] sum_o
);
    logic [ACC_W-1:0] acc_ff;
    logic [ACC_W:0]   sum_w;

    // Running total including this cycle's input
    assign sum_w = {1'b0, acc_ff} + (ACC_W + 1)'(in_i);
    assign sum_o = sum_w[ACC_W] ? {ACC_W{1'b1}} : sum_w[ACC_W-1:0];

    // Clear after the second is read; the clearing cycle is already in sum_o
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i || clr_i)
        begin
            acc_ff <= '0;
        end
        else
        begin
            acc_ff <= sum_o;
        end
    end
endmodule

// ==== hw/psc_perf_counters.sv ====
// Per-second classification and availability counting for a pattern test
//
// Contract
// R01: Total time counts seconds, skipping power loss
// R02: Errored second: available, any pattern error
// R03: Severe second: ratio 1e-3, LOF or LOS
// R04: Alarm second: link down, fault, LOF, frames
// R05: Ten bad seconds start unavailability at first
// R06: Ten non-severe seconds end unavailability before
// R07: Pending start counted available, then recounted
// R08: Pending end counted unavailable, then recounted
// R09: Other counts revised the same way
// R10: Available time is total minus unavailable
// R11: Error-free second: available, no error at all
// R12: Own tick, latch indications, clear each second
`timescale 1ns/1ps
module psc_perf_counters #(
    parameter int unsigned TICK_CYCLES = psc_pkg::TICK_CYCLES
) (
    input  wire logic                clk_i,
    input  wire logic                rstn_i,
    input  wire logic                meas_start_i,
    input  wire logic                power_good_i,
    input  wire psc_pkg::psc_rx_ind_t rx_i,
    output psc_pkg::psc_counts_t     counts_o,
    output logic                     unavailable_o,
    output logic                     sec_done_o
);
    localparam int unsigned CNT_W = psc_pkg::CNT_W;
    localparam int unsigned RUN_W = psc_pkg::RUN_W;

    logic                          pg_meta_ff;
    logic                          pg_sync_ff;
    logic [31:0]                   tick_cnt_ff;
    logic                          sec_tick;
    logic                          latch_clr;
    logic [psc_pkg::ERR_AW-1:0]    err_sum;
    logic [psc_pkg::BIT_AW-1:0]    bit_sum;
    logic [psc_pkg::FLAG_N-1:0]    flag_in;
    logic [psc_pkg::FLAG_N-1:0]    flag_sum;
    logic [psc_pkg::PROD_W-1:0]    err_scaled;
    logic                          ratio_bad;
    logic                          sec_valid;
    logic                          sec_es;
    logic                          sec_ses;
    logic                          sec_als;
    logic                          sec_ef;
    logic                          sec_bad;

    psc_pkg::psc_state_t           state_ff;
    psc_pkg::psc_state_t           nxt_state;
    logic [RUN_W-1:0]              run_ff;
    logic [RUN_W-1:0]              nxt_run;
    logic [RUN_W-1:0]              pend_es_ff;
    logic [RUN_W-1:0]              pend_ses_ff;
    logic [RUN_W-1:0]              pend_als_ff;
    logic [RUN_W-1:0]              pend_ef_ff;
    logic [RUN_W-1:0]              nxt_pend_es;
    logic [RUN_W-1:0]              nxt_pend_ses;
    logic [RUN_W-1:0]              nxt_pend_als;
    logic [RUN_W-1:0]              nxt_pend_ef;
    psc_pkg::psc_cnt_t             total_ff;
    psc_pkg::psc_cnt_t             unav_ff;
    psc_pkg::psc_cnt_t             avail_ff;
    psc_pkg::psc_cnt_t             es_ff;
    psc_pkg::psc_cnt_t             ses_ff;
    psc_pkg::psc_cnt_t             als_ff;
    psc_pkg::psc_cnt_t             efs_ff;
    psc_pkg::psc_cnt_t             nxt_total;
    psc_pkg::psc_cnt_t             nxt_unav;
    psc_pkg::psc_cnt_t             nxt_es;
    psc_pkg::psc_cnt_t             nxt_ses;
    psc_pkg::psc_cnt_t             nxt_als;
    psc_pkg::psc_cnt_t             nxt_efs;
    logic                          sec_done_ff;

    // Power-good pin crosses in through two flops
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            pg_meta_ff <= 1'b0;
            pg_sync_ff <= 1'b0;
        end
        else
        begin
            pg_meta_ff <= power_good_i;
            pg_sync_ff <= pg_meta_ff;
        end
    end

    // One-second tick, restarted at measurement start
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i || meas_start_i || sec_tick)
        begin
            tick_cnt_ff <= 32'h0;
        end
        else
        begin
            tick_cnt_ff <= tick_cnt_ff + 32'h1;
        end
    end
    assign sec_tick  = (tick_cnt_ff == 32'(TICK_CYCLES - 1)); // [R12]
    assign latch_clr = sec_tick | meas_start_i;               // [R12]

    // Pattern error and checked-bit totals over the second
    psc_sec_latch #(
        .IN_W  (psc_pkg::IN_W),
        .ACC_W (psc_pkg::ERR_AW)
    ) u_err_acc (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .clr_i  (latch_clr),
        .in_i   (rx_i.pat_err_cnt),
        .sum_o  (err_sum)
    );

    psc_sec_latch #(
        .IN_W  (psc_pkg::IN_W),
        .ACC_W (psc_pkg::BIT_AW)
    ) u_bit_acc (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .clr_i  (latch_clr),
        .in_i   (rx_i.pat_bit_cnt),
        .sum_o  (bit_sum)
    );

    // Sticky alarm flags: LOF, LOS, link down, fault, bad frame, power lost
    assign flag_in = {rx_i.lof, rx_i.los, ~rx_i.link_up, rx_i.remote_fault,
                      rx_i.errored_frame, ~pg_sync_ff};

    for (genvar g = 0; g < psc_pkg::FLAG_N; g++)
    begin : g_flag
        psc_sec_latch #(
            .IN_W  (1),
            .ACC_W (1)
        ) u_flag (
            .clk_i  (clk_i),
            .rstn_i (rstn_i),
            .clr_i  (latch_clr),                            // [R12]
            .in_i   (flag_in[g]),
            .sum_o  (flag_sum[g])
        );
    end

    // Classification of the second that ends on this tick
    assign err_scaled = psc_pkg::PROD_W'(err_sum)
                      * psc_pkg::PROD_W'(psc_pkg::SES_RATIO_INV);
    assign ratio_bad  = (err_sum != '0)
                      && (err_scaled >= psc_pkg::PROD_W'(bit_sum)); // [R03]
    assign sec_valid  = sec_tick & ~flag_sum[0];                    // [R01]
    assign sec_es     = (err_sum != '0);                            // [R02]
    assign sec_ses    = ratio_bad | flag_sum[5] | flag_sum[4];      // [R03]
    assign sec_als    = flag_sum[3] | flag_sum[2] | flag_sum[5]
                      | flag_sum[1];                                // [R04]
    assign sec_ef     = ~(sec_es | sec_ses | sec_als);              // [R11]
    assign sec_bad    = sec_ses | sec_als;                          // [R05]

    // Availability tracking and provisional counting
    always_comb
    begin
        nxt_state    = state_ff;
        nxt_run      = run_ff;
        nxt_pend_es  = pend_es_ff;
        nxt_pend_ses = pend_ses_ff;
        nxt_pend_als = pend_als_ff;
        nxt_pend_ef  = pend_ef_ff;
        nxt_total    = total_ff;
        nxt_unav     = unav_ff;
        nxt_es       = es_ff;
        nxt_ses      = ses_ff;
        nxt_als      = als_ff;
        nxt_efs      = efs_ff;
        if (sec_valid)
        begin
            nxt_total = total_ff + CNT_W'(1'b1);                    // [R01]
            // Run and pending counts restart unless a path extends them
            nxt_run      = psc_pkg::RUN_RST;
            nxt_pend_es  = psc_pkg::RUN_RST;
            nxt_pend_ses = psc_pkg::RUN_RST;
            nxt_pend_als = psc_pkg::RUN_RST;
            nxt_pend_ef  = psc_pkg::RUN_RST;
            case (state_ff)
                psc_pkg::PSC_AVAIL,
                psc_pkg::PSC_ENTER:
                begin
                    if (sec_bad && state_ff == psc_pkg::PSC_ENTER
                        && run_ff == psc_pkg::RUN_LAST)
                    begin
                        // Start confirmed: take back the run from the counts
                        nxt_unav     = unav_ff + psc_pkg::WIN_CNT;          // [R05]
                        nxt_es       = es_ff - CNT_W'(pend_es_ff);          // [R07]
                        nxt_ses      = ses_ff - CNT_W'(pend_ses_ff);        // [R09]
                        nxt_als      = als_ff - CNT_W'(pend_als_ff);        // [R09]
                        nxt_efs      = efs_ff - CNT_W'(pend_ef_ff);         // [R09]
                        nxt_state    = psc_pkg::PSC_UNAV;
                    end
                    else
                    begin
                        // Still available: count now, remember while pending
                        nxt_es  = es_ff + CNT_W'(sec_es);                   // [R02]
                        nxt_ses = ses_ff + CNT_W'(sec_ses);                 // [R03]
                        nxt_als = als_ff + CNT_W'(sec_als);                 // [R04]
                        nxt_efs = efs_ff + CNT_W'(sec_ef);                  // [R11]
                        if (sec_bad)
                        begin
                            nxt_state    = psc_pkg::PSC_ENTER;              // [R07]
                            nxt_run      = run_ff + RUN_W'(1'b1);
                            nxt_pend_es  = pend_es_ff + RUN_W'(sec_es);
                            nxt_pend_ses = pend_ses_ff + RUN_W'(sec_ses);
                            nxt_pend_als = pend_als_ff + RUN_W'(sec_als);
                            nxt_pend_ef  = pend_ef_ff + RUN_W'(sec_ef);
                        end
                        else
                        begin
                            nxt_state    = psc_pkg::PSC_AVAIL;
                        end
                    end
                end
                psc_pkg::PSC_UNAV,
                psc_pkg::PSC_LEAVE:
                begin
                    if (!sec_ses && state_ff == psc_pkg::PSC_LEAVE
                        && run_ff == psc_pkg::RUN_LAST)
                    begin
                        // End confirmed: give the run back to available time
                        nxt_unav     = unav_ff - psc_pkg::LEAVE_SUB;        // [R06] [R08]
                        nxt_es       = es_ff + CNT_W'(pend_es_ff)
                                     + CNT_W'(sec_es);                      // [R09]
                        nxt_ses      = ses_ff + CNT_W'(pend_ses_ff);        // [R09]
                        nxt_als      = als_ff + CNT_W'(pend_als_ff)
                                     + CNT_W'(sec_als);                     // [R09]
                        nxt_efs      = efs_ff + CNT_W'(pend_ef_ff)
                                     + CNT_W'(sec_ef);                      // [R09]
                        nxt_state    = psc_pkg::PSC_AVAIL;
                    end
                    else
                    begin
                        // Counted unavailable until the end is confirmed
                        nxt_unav = unav_ff + CNT_W'(1'b1);                  // [R08]
                        if (!sec_ses)
                        begin
                            nxt_state    = psc_pkg::PSC_LEAVE;              // [R06]
                            nxt_run      = run_ff + RUN_W'(1'b1);
                            nxt_pend_es  = pend_es_ff + RUN_W'(sec_es);
                            nxt_pend_ses = pend_ses_ff;
                            nxt_pend_als = pend_als_ff + RUN_W'(sec_als);
                            nxt_pend_ef  = pend_ef_ff + RUN_W'(sec_ef);
                        end
                        else
                        begin
                            nxt_state    = psc_pkg::PSC_UNAV;
                        end
                    end
                end
                default:
                begin
                    nxt_state = psc_pkg::PSC_AVAIL;
                end
            endcase
        end
    end

    // State and pending run, cleared at measurement start
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i || meas_start_i)
        begin
            state_ff    <= psc_pkg::PSC_AVAIL;
            run_ff      <= psc_pkg::RUN_RST;
            pend_es_ff  <= psc_pkg::RUN_RST;
            pend_ses_ff <= psc_pkg::RUN_RST;
            pend_als_ff <= psc_pkg::RUN_RST;
            pend_ef_ff  <= psc_pkg::RUN_RST;
        end
        else
        begin
            state_ff    <= nxt_state;
            run_ff      <= nxt_run;
            pend_es_ff  <= nxt_pend_es;
            pend_ses_ff <= nxt_pend_ses;
            pend_als_ff <= nxt_pend_als;
            pend_ef_ff  <= nxt_pend_ef;
        end
    end

    // Result counters, cleared at measurement start
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i || meas_start_i)
        begin
            total_ff <= psc_pkg::CNT_RST;
            unav_ff  <= psc_pkg::CNT_RST;
            avail_ff <= psc_pkg::CNT_RST;
            es_ff    <= psc_pkg::CNT_RST;
            ses_ff   <= psc_pkg::CNT_RST;
            als_ff   <= psc_pkg::CNT_RST;
            efs_ff   <= psc_pkg::CNT_RST;
        end
        else
        begin
            total_ff <= nxt_total;
            unav_ff  <= nxt_unav;
            avail_ff <= nxt_total - nxt_unav;                       // [R10]
            es_ff    <= nxt_es;
            ses_ff   <= nxt_ses;
            als_ff   <= nxt_als;
            efs_ff   <= nxt_efs;
        end
    end

    // Pulse when a second's results land in the counters
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i || meas_start_i)
        begin
            sec_done_ff <= 1'b0;
        end
        else
        begin
            sec_done_ff <= sec_valid;
        end
    end

    // Outputs
    assign counts_o.total_time              = total_ff;
    assign counts_o.unavailable_time        = unav_ff;
    assign counts_o.available_time          = avail_ff;
    assign counts_o.errored_seconds         = es_ff;
    assign counts_o.severe_errored_seconds  = ses_ff;
    assign counts_o.alarm_second_count      = als_ff;
    assign counts_o.error_free_second_count = efs_ff;
    assign unavailable_o = state_ff[1];   // UNAV or LEAVE, from a flop
    assign sec_done_o    = sec_done_ff;
endmodule

// ==== sim/psc_perf_counters_assertions.sv ====
// Concurrent checks on the ports of the performance counter block
`timescale 1ns/1ps
module psc_perf_counters_assertions #(
    parameter int unsigned TICK_CYCLES = psc_pkg::TICK_CYCLES
) (
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    input  wire logic                 meas_start_i,
    input  wire psc_pkg::psc_counts_t counts_o,
    input  wire logic                 unavailable_o,
    input  wire logic                 sec_done_o
);
    logic [31:0] gap_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // Cycles since the last classified second or restart
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i || meas_start_i || sec_done_o)
            gap_ff <= 32'h0;
        else
            gap_ff <= gap_ff + 32'h1;
    end

    property p_pulse_one;
        sec_done_o |=> !sec_done_o;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("second pulse too long");
    property p_gap;
        sec_done_o |-> gap_ff >= TICK_CYCLES - 1;
    endproperty
    a_gap: assert property (p_gap) else $error("seconds closer than one tick");
    property p_total_step;
        sec_done_o |-> counts_o.total_time == $past(counts_o.total_time) + 32'h1;
    endproperty
    a_total_step: assert property (p_total_step) else $error("total not stepped");
    property p_total_hold;
        !meas_start_i ##1 !sec_done_o |-> $stable(counts_o.total_time);
    endproperty
    a_total_hold: assert property (p_total_hold) else $error("total moved off tick");
    property p_avail_sum;
        counts_o.available_time == counts_o.total_time - counts_o.unavailable_time;
    endproperty
    a_avail_sum: assert property (p_avail_sum) else $error("available time mismatch");
    property p_start_clear;
        meas_start_i |=> counts_o == '0 && !unavailable_o && !sec_done_o;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("restart not cleared");
    property p_enter_jump;
        $rose(unavailable_o) |-> counts_o.unavailable_time == $past(counts_o.unavailable_time) + 32'ha;
    endproperty
    a_enter_jump: assert property (p_enter_jump) else $error("entry not ten");
    property p_leave_drop;
        $fell(unavailable_o) && sec_done_o
            |-> counts_o.unavailable_time == $past(counts_o.unavailable_time) - 32'h9;
    endproperty
    a_leave_drop: assert property (p_leave_drop) else $error("exit not minus nine");
    property p_unav_step;
        sec_done_o && unavailable_o && $past(unavailable_o)
            |-> counts_o.unavailable_time == $past(counts_o.unavailable_time) + 32'h1;
    endproperty
    a_unav_step: assert property (p_unav_step) else $error("unavailable not stepped");
    property p_avail_hold;
        sec_done_o && !unavailable_o && !$past(unavailable_o) |-> $stable(counts_o.unavailable_time);
    endproperty
    a_avail_hold: assert property (p_avail_hold) else $error("unavailable moved");
endmodule

bind psc_perf_counters psc_perf_counters_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .meas_start_i(meas_start_i), .counts_o(counts_o),
    .unavailable_o(unavailable_o), .sec_done_o(sec_done_o));

// ==== sim/psc_rx_model.sv ====
// Receive-path detector model driving one indication pattern per mode
`timescale 1ns/1ps
module psc_rx_model (
    input  wire logic           clk_i,
    input  wire logic [3:0]     mode_i,
    output psc_pkg::psc_rx_ind_t rx_o
);
    logic ph_ff = 1'b0;

    // Flags show only in every other cycle, so the block must hold them
    always_ff @(negedge clk_i)
        ph_ff <= ~ph_ff;

    // Mode 2 sits exactly on the severe ratio, mode 3 just below it
    always_comb
    begin
        rx_o               = '0;
        rx_o.pat_err_cnt   = (mode_i inside {4'h1, 4'h2, 4'h3}) ? 16'h0001 : 16'h0000;
        rx_o.pat_bit_cnt   = (mode_i == 4'h2) ? 16'h03e8 : (mode_i == 4'h3) ? 16'h03e9 : 16'hffff;
        rx_o.lof           = ph_ff && mode_i == 4'h4;
        rx_o.los           = ph_ff && mode_i == 4'h5;
        rx_o.link_up       = !(ph_ff && mode_i == 4'h6);
        rx_o.remote_fault  = ph_ff && mode_i == 4'h7;
        rx_o.errored_frame = ph_ff && mode_i == 4'h8;
    end
endmodule

// ==== sim/psc_perf_counters_tb.sv ====
// Self-checking testbench for the per-second performance counters
`timescale 1ns/1ps
`define PSC_CHECK(nm, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module psc_perf_counters_tb;
    localparam int unsigned TICK = 4;
    // Per mode: errored, severe, alarm
    localparam logic [2:0] CLS [9] = '{3'h0, 3'h4, 3'h6, 3'h4, 3'h3, 3'h2, 3'h1, 3'h1, 3'h1};
    logic                 clk_i, rstn_i, meas_start_i, power_good_i, unavailable_o, sec_done_o;
    logic [3:0]           mode;
    psc_pkg::psc_rx_ind_t rx_i;
    psc_pkg::psc_counts_t counts_o;
    psc_pkg::psc_cnt_t    m [4];
    psc_pkg::psc_cnt_t    p [4];
    psc_pkg::psc_cnt_t    tot, unv;
    logic                 uf;
    int                   run, fails, n_checks, cyc;

    psc_perf_counters #(.TICK_CYCLES(TICK)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .meas_start_i(meas_start_i), .power_good_i(power_good_i), .rx_i(rx_i),
        .counts_o(counts_o), .unavailable_o(unavailable_o), .sec_done_o(sec_done_o));
    psc_rx_model u_rx (.clk_i(clk_i), .mode_i(mode), .rx_o(rx_i));

    // Expected counts after one classified second
    function automatic void model(input logic [2:0] c);
        psc_pkg::psc_cnt_t cur [4];
        logic              bad;
        cur = '{32'(c[2]), 32'(c[1]), 32'(c[0]), 32'(c == 3'h0)};
        bad = c[1] | c[0];
        tot++;
        if (!uf && bad && run == 9)
        begin
            unv += 32'ha;
            for (int i = 0; i < 4; i++)
                m[i] -= p[i];
            uf = 1'b1;
        end
        else if (uf && !c[1] && run == 9)
        begin
            unv -= 32'h9;
            for (int i = 0; i < 4; i++)
                m[i] += p[i] + cur[i];
            uf = 1'b0;
        end
        else
        begin
            unv += 32'(uf);
            for (int i = 0; i < 4; i++)
                m[i] += uf ? 32'h0 : cur[i];
            if (uf ? !c[1] : bad)
            begin
                run++;
                for (int i = 0; i < 4; i++)
                    p[i] += cur[i];
                return;
            end
        end
        run = 0;
        p = '{default: '0};
    endfunction

    task automatic cmp_all();
        `PSC_CHECK("total_time", tot, counts_o.total_time)
        `PSC_CHECK("unavailable_time", unv, counts_o.unavailable_time)
        `PSC_CHECK("available_time", tot - unv, counts_o.available_time)
        `PSC_CHECK("errored_seconds", m[0], counts_o.errored_seconds)
        `PSC_CHECK("severe_errored_seconds", m[1], counts_o.severe_errored_seconds)
        `PSC_CHECK("alarm_second_count", m[2], counts_o.alarm_second_count)
        `PSC_CHECK("error_free_second_count", m[3], counts_o.error_free_second_count)
        `PSC_CHECK("unavailable_o", uf, unavailable_o)
    endtask

    // One second of mode k, optionally with a one-cycle power dip
    task automatic sec(input int k, input logic drop);
        mode = 4'(k);
        @(negedge clk_i);
        power_good_i = !drop;
        @(negedge clk_i);
        power_good_i = 1'b1;
        repeat (TICK - 2) @(negedge clk_i);
        `PSC_CHECK("sec_done_o", !drop, sec_done_o)
        if (!drop)
            model(CLS[k]);
        cmp_all();
    endtask

    task automatic start_meas();
        meas_start_i = 1'b1;
        @(negedge clk_i);
        meas_start_i = 1'b0;
        tot = '0;
        unv = '0;
        uf = 1'b0;
        run = 0;
        m = '{default: '0};
        p = '{default: '0};
        cmp_all();
    endtask

    task automatic t_classes();
        start_meas();
        for (int k = 0; k < 9; k++)
            sec(k, 1'b0);
        $display("test classes done");
    endtask

    task automatic t_unavail();
        start_meas();
        repeat (9) sec(4, 1'b0);
        sec(0, 1'b0);
        repeat (10) sec(4, 1'b0);
        repeat (3) sec(5, 1'b0);
        repeat (5) sec(6, 1'b0);
        sec(2, 1'b0);
        repeat (10) sec(1, 1'b0);
        $display("test unavailable done");
    endtask

    task automatic t_power_restart();
        sec(7, 1'b1);
        sec(7, 1'b0);
        repeat (10) sec(5, 1'b0);
        start_meas();
        sec(0, 1'b0);
        $display("test power and restart done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // 25 ns clock
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Cut a hang short
    initial
    begin
        cyc = 0;
        forever
        begin
            @(posedge clk_i);
            cyc++;
            if (cyc == 2000)
            begin
                fails++;
                complete_run();
            end
        end
    end

    initial
    begin
        rstn_i = 1'b0;
        meas_start_i = 1'b0;
        power_good_i = 1'b1;
        mode = 4'h0;
        fails = 0;
        n_checks = 0;
        repeat (2) @(negedge clk_i);
        rstn_i = 1'b1;
        @(negedge clk_i);
        tot = '0;
        unv = '0;
        uf = 1'b0;
        m = '{default: '0};
        cmp_all();
        repeat (4) @(negedge clk_i);
        t_classes();
        t_unavail();
        t_power_restart();
        complete_run();
    end
endmodule
